// ===== core/trp_csum.sv
// running negated-sum checksum accumulator
`timescale 1ns/10ps
`default_nettype none
module trp_csum #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic         clear,
   input  wire logic         add,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] sum_q,
   output logic              zero
);
   logic [W-1:0] sum_d;

   // clear wins so a new block starts from zero
   always_comb begin
      sum_d = sum_q;
      if (clear) begin
         sum_d = '0;
      end else if (add) begin
         sum_d = W'(sum_q + din);
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sum_q <= '0;
      end else begin
         sum_q <= sum_d;
      end
   end

   // sum plus incoming byte; zero means the trailing checksum fits
   assign zero = (W'(sum_q + din) == '0);
endmodule : trp_csum
`default_nettype wire

// ===== core/trp_parser.sv
// tape record parser: sync hunt, header decode, data delivery
`timescale 1ns/10ps
`include "trp_map.svh"
`default_nettype none
module trp_parser #(
   parameter int NAME_BYTES = 8
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        in_valid,
   input  wire logic [7:0]  in_data,
   input  wire logic        err_clear,
   output logic             hdr_valid,
   output logic [63:0]      rec_name,
   output logic [15:0]      rec_number,
   output logic [7:0]       record_type,
   output logic [8:0]       block_length,
   output logic [15:0]      rec_addr,
   output logic             mem_we,
   output logic [15:0]      mem_addr,
   output logic [7:0]       mem_data,
   output logic             buf_valid,
   output logic [7:0]       buf_data,
   output logic             disp_valid,
   output logic [7:0]       disp_data,
   output logic             src_stop,
   output logic             exec_req,
   output logic [15:0]      exec_addr,
   output logic             rec_done,
   output logic             csum_err,
   output logic             load_halt
);
   trp_pkg::trp_state_e state_q, state_d;
   logic [4:0]  sync_cnt_q, sync_cnt_d;
   logic [3:0]  hidx_q, hidx_d;
   logic [8:0]  left_q, left_d;
   logic [63:0] name_q, name_d;
   logic [15:0] num_q, num_d, addr_q, addr_d, wptr_q, wptr_d;
   logic [7:0]  len_q, len_d, type_q, type_d;
   logic        hdr_valid_d, mem_we_d, buf_valid_d, disp_valid_d;
   logic        src_stop_d, exec_req_d, rec_done_d, csum_err_d;
   logic        load_halt_d;
   logic [15:0] exec_addr_d;
   logic [7:0]  out_byte_d;
   logic        sum_clear, sum_add, sum_zero;
   // only the zero test of the running sum is needed here

   // one accumulator, cleared per block, shared by header and data
   trp_csum #(.W(8)) u_csum (
      .clk   (clk),
      .nrst  (nrst),
      .clear (sum_clear),
      .add   (sum_add),
      .din   (in_data),
      .sum_q (),
      .zero  (sum_zero)
   );

   // record sequencer; every byte is taken the cycle it arrives
   always_comb begin
      state_d      = state_q;
      sync_cnt_d   = sync_cnt_q;
      hidx_d       = hidx_q;
      left_d       = left_q;
      name_d       = name_q;
      num_d        = num_q;
      addr_d       = addr_q;
      len_d        = len_q;
      type_d       = type_q;
      wptr_d       = wptr_q;
      hdr_valid_d  = 1'b0;
      mem_we_d     = 1'b0;
      buf_valid_d  = 1'b0;
      disp_valid_d = 1'b0;
      src_stop_d   = 1'b0;
      exec_req_d   = 1'b0;
      rec_done_d   = 1'b0;
      csum_err_d   = csum_err;
      load_halt_d  = load_halt;
      exec_addr_d  = exec_addr;
      out_byte_d   = in_data;
      sum_clear    = 1'b0;
      sum_add      = 1'b0;
      // software clear loses to a fresh error raised below
      if (err_clear) begin
         csum_err_d  = 1'b0;
         load_halt_d = 1'b0;
      end
      if (in_valid) begin
         unique case (state_q)
            trp_pkg::TRP_HUNT: begin
               // idle bytes of any count just keep us hunting
               if (in_data == `TRP_SYNC_BYTE) begin
                  if (sync_cnt_q == `TRP_SYNC_COUNT - 5'h01) begin
                     state_d = trp_pkg::TRP_SOH;
                  end else begin
                     sync_cnt_d = 5'(sync_cnt_q + 5'h01);
                  end
               end else begin
                  sync_cnt_d = '0;
               end
            end
            trp_pkg::TRP_SOH: begin
               sync_cnt_d = '0;
               sum_clear  = 1'b1;
               hidx_d     = '0;
               // a 17th sync breaks the exact-run framing
               if (in_data == `TRP_SOH_BYTE) begin
                  state_d = trp_pkg::TRP_HEADER;
               end else begin
                  state_d = trp_pkg::TRP_HUNT;
               end
            end
            trp_pkg::TRP_HEADER: begin
               sum_add = 1'b1;
               hidx_d  = 4'(hidx_q + 4'h1);
               // fields land by position in the header
               if (hidx_q < `TRP_NAME_LEN) begin
                  name_d = {name_q[55:0], in_data};
               end
               if (hidx_q == `TRP_OFS_NUM_LO) begin
                  num_d[7:0] = in_data;
               end
               if (hidx_q == `TRP_OFS_NUM_HI) begin
                  num_d[15:8] = in_data;
               end
               if (hidx_q == `TRP_OFS_LEN) begin
                  len_d = in_data;
               end
               if (hidx_q == `TRP_OFS_ADR_LO) begin
                  addr_d[7:0] = in_data;
               end
               if (hidx_q == `TRP_OFS_ADR_HI) begin
                  addr_d[15:8] = in_data;
               end
               if (hidx_q == `TRP_OFS_TYPE) begin
                  type_d = in_data;
               end
               if (hidx_q == `TRP_OFS_CSUM) begin
                  sum_clear = 1'b1;
                  sum_add   = 1'b0;
                  state_d   = trp_pkg::TRP_HUNT;
                  if (!sum_zero) begin
                     // silent drop, hunt afresh
                     state_d = trp_pkg::TRP_HUNT;
                  end else begin
                     hdr_valid_d = 1'b1;
                     // zero length is 256 bytes
                     left_d = (len_q == 8'h00) ? 9'h100 : {1'b0, len_q};
                     wptr_d = addr_q;
                     unique case (type_q)
                        `TRP_TYPE_ABS, `TRP_TYPE_COMM, `TRP_TYPE_DATA: begin
                           state_d = trp_pkg::TRP_DATA;
                        end
                        `TRP_TYPE_END: begin
                           src_stop_d = 1'b1;
                           rec_done_d = 1'b1;
                        end
                        `TRP_TYPE_EXEC: begin
                           exec_req_d  = 1'b1;
                           exec_addr_d = addr_q;
                           rec_done_d  = 1'b1;
                        end
                        default: begin
                           rec_done_d = 1'b1;
                        end
                     endcase
                  end
               end
            end
            trp_pkg::TRP_DATA: begin
               sum_add = 1'b1;
               left_d  = 9'(left_q - 9'h001);
               unique case (type_q)
                  `TRP_TYPE_ABS: begin
                     mem_we_d = ~load_halt;
                     wptr_d   = 16'(wptr_q + 16'h0001);
                  end
                  `TRP_TYPE_COMM: begin
                     disp_valid_d = 1'b1;
                  end
                  default: begin
                     buf_valid_d = ~load_halt;
                  end
               endcase
               if (left_q == 9'h001) begin
                  state_d = trp_pkg::TRP_DCSUM;
               end
            end
            trp_pkg::TRP_DCSUM: begin
               sum_clear  = 1'b1;
               state_d    = trp_pkg::TRP_HUNT;
               rec_done_d = 1'b1;
               if (!sum_zero && type_q != `TRP_TYPE_COMM) begin
                  csum_err_d  = 1'b1;
                  load_halt_d = 1'b1;
               end else if (sum_zero && load_halt) begin
                  // a clean re-read of any data-carrying record lifts the halt
                  load_halt_d = 1'b0;
               end
            end
            default: begin
               state_d = trp_pkg::TRP_HUNT;
            end
         endcase
      end
   end

   // registers and registered outputs
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q      <= trp_pkg::TRP_HUNT;
         sync_cnt_q   <= '0;
         hidx_q       <= '0;
         left_q       <= '0;
         name_q       <= '0;
         num_q        <= '0;
         addr_q       <= '0;
         len_q        <= '0;
         type_q       <= '0;
         wptr_q       <= '0;
         hdr_valid    <= 1'b0;
         rec_name     <= '0;
         rec_number   <= '0;
         record_type  <= '0;
         block_length <= '0;
         rec_addr     <= '0;
         mem_we       <= 1'b0;
         mem_addr     <= '0;
         mem_data     <= '0;
         buf_valid    <= 1'b0;
         buf_data     <= '0;
         disp_valid   <= 1'b0;
         disp_data    <= '0;
         src_stop     <= 1'b0;
         exec_req     <= 1'b0;
         exec_addr    <= '0;
         rec_done     <= 1'b0;
         csum_err     <= 1'b0;
         load_halt    <= 1'b0;
      end else begin
         state_q      <= state_d;
         sync_cnt_q   <= sync_cnt_d;
         hidx_q       <= hidx_d;
         left_q       <= left_d;
         name_q       <= name_d;
         num_q        <= num_d;
         addr_q       <= addr_d;
         len_q        <= len_d;
         type_q       <= type_d;
         wptr_q       <= wptr_d;
         hdr_valid    <= hdr_valid_d;
         mem_we       <= mem_we_d;
         mem_addr     <= wptr_q;
         mem_data     <= out_byte_d;
         buf_valid    <= buf_valid_d;
         buf_data     <= out_byte_d;
         disp_valid   <= disp_valid_d;
         disp_data    <= out_byte_d;
         src_stop     <= src_stop_d;
         exec_req     <= exec_req_d;
         exec_addr    <= exec_addr_d;
         rec_done     <= rec_done_d;
         csum_err     <= csum_err_d;
         load_halt    <= load_halt_d;
         if (hdr_valid_d) begin
            rec_name     <= name_q;
            rec_number   <= num_q;
            record_type  <= type_q;
            block_length <= left_d;
            rec_addr     <= addr_q;
         end
      end
   end
endmodule : trp_parser
`default_nettype wire

// ===== include/trp_map.svh
// offsets, byte values and counts for the tape record parser
`ifndef TRP_MAP_SVH
`define TRP_MAP_SVH
`define TRP_SYNC_BYTE   8'he6
`define TRP_SOH_BYTE    8'h01
`define TRP_SYNC_COUNT  5'h10
`define TRP_NAME_LEN    4'h8
`define TRP_HDR_LEN     4'hf
`define TRP_OFS_NUM_LO  4'h8
`define TRP_OFS_NUM_HI  4'h9
`define TRP_OFS_LEN     4'ha
`define TRP_OFS_ADR_LO  4'hb
`define TRP_OFS_ADR_HI  4'hc
`define TRP_OFS_TYPE    4'hd
`define TRP_OFS_CSUM    4'he
`define TRP_TYPE_ABS    8'h00
`define TRP_TYPE_COMM   8'h01
`define TRP_TYPE_END    8'h02
`define TRP_TYPE_EXEC   8'h03
`define TRP_TYPE_DATA   8'h04
`endif

// ===== include/trp_pkg.sv
// types shared by the tape record parser
package trp_pkg;
   typedef enum logic [4:0] {
      TRP_HUNT   = 5'b00001,
      TRP_SOH    = 5'b00010,
      TRP_HEADER = 5'b00100,
      TRP_DATA   = 5'b01000,
      TRP_DCSUM  = 5'b10000
   } trp_state_e;
   typedef logic [7:0] trp_byte_t;
endpackage : trp_pkg

// ===== tb/trp_byte_src.sv
// byte source standing in for the cassette side
`timescale 1ns/10ps
`default_nettype none
module trp_byte_src (
   input  wire logic       clk,
   output var  logic       in_valid,
   output var  logic [7:0] in_data
);
   initial begin
      in_valid = 1'b0;
      in_data  = 8'h00;
   end
   // one strobe per byte; idle line shows the inverse, never a stale byte
   task automatic send(input logic [7:0] b, input int gap);
      in_valid <= 1'b1;
      in_data  <= b;
      @(posedge clk);
      if (gap > 0) begin
         in_valid <= 1'b0;
         in_data  <= ~b;
         repeat (gap) @(posedge clk);
      end
   endtask : send
endmodule : trp_byte_src
`default_nettype wire

// ===== tb/trp_parser_sva.sv
// assertion checker for the tape record parser
`timescale 1ns/10ps
`default_nettype none
module trp_parser_sva (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        in_valid,
   input wire logic [7:0]  in_data,
   input wire logic        err_clear,
   input wire logic        hdr_valid,
   input wire logic [7:0]  record_type,
   input wire logic [8:0]  block_length,
   input wire logic [15:0] rec_addr,
   input wire logic        mem_we,
   input wire logic [15:0] mem_addr,
   input wire logic [7:0]  mem_data,
   input wire logic        buf_valid,
   input wire logic        disp_valid,
   input wire logic        src_stop,
   input wire logic        exec_req,
   input wire logic [15:0] exec_addr,
   input wire logic        rec_done,
   input wire logic        csum_err,
   input wire logic        load_halt
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // header pulses of the two data-less record kinds
   sequence end_hdr_s; hdr_valid && record_type == 8'h02; endsequence
   sequence exec_hdr_s; hdr_valid && record_type == 8'h03; endsequence
   stop_on_end_a: assert property (src_stop |-> end_hdr_s)
      else $error("source stop without end header");
   exec_target_a: assert property (exec_req |->
      exec_hdr_s ##0 exec_addr == rec_addr)
      else $error("jump request wrong");
   end_done_a: assert property (end_hdr_s |-> ##[0:1] rec_done)
      else $error("end record not finished");
   abs_write_a: assert property (mem_we |-> record_type == 8'h00 && !load_halt
      && $past(in_valid) && mem_data == $past(in_data))
      else $error("memory write wrong");
   addr_step_a: assert property (mem_we && $past(mem_we) |->
      mem_addr == $past(mem_addr) + 16'h0001)
      else $error("write address not rising");
   buf_kind_a: assert property (buf_valid |->
      record_type == 8'h04 && !load_halt)
      else $error("buffer byte from wrong record");
   disp_kind_a: assert property (disp_valid |-> record_type == 8'h01)
      else $error("display byte from wrong record");
   err_rise_a: assert property ($rose(csum_err) |-> rec_done && load_halt
      && record_type != 8'h01)
      else $error("checksum error raised wrongly");
   err_clear_a: assert property (err_clear |=> !csum_err || rec_done)
      else $error("error not cleared");
   len_zero_a: assert property (hdr_valid && record_type == 8'h00 |->
      block_length != 9'h000)
      else $error("zero block length");
endmodule : trp_parser_sva
bind trp_parser trp_parser_sva u_sva (.clk(clk), .nrst(nrst),
   .in_valid(in_valid), .in_data(in_data), .err_clear(err_clear),
   .hdr_valid(hdr_valid), .record_type(record_type),
   .block_length(block_length), .rec_addr(rec_addr), .mem_we(mem_we),
   .mem_addr(mem_addr), .mem_data(mem_data), .buf_valid(buf_valid),
   .disp_valid(disp_valid), .src_stop(src_stop), .exec_req(exec_req),
   .exec_addr(exec_addr), .rec_done(rec_done), .csum_err(csum_err),
   .load_halt(load_halt));
`default_nettype wire

// ===== tb/trp_parser_tb.sv
// self-checking bench for the tape record parser
`timescale 1ns/10ps
`default_nettype none
module trp_parser_tb;
   logic clk = 1'b0, nrst = 1'b0, err_clear = 1'b0, in_valid;
   logic [7:0] in_data, record_type, mem_data, buf_data, disp_data;
   logic [63:0] rec_name;
   logic [15:0] rec_number, rec_addr, mem_addr, exec_addr;
   logic [8:0] block_length;
   logic hdr_valid, mem_we, buf_valid, disp_valid, src_stop, exec_req;
   logic rec_done, csum_err, load_halt;
   int miscompares = 0, check_count = 0, cycles = 0, stops = 0, stop_exp = 0;
   logic [7:0] q[$];
   logic [112:0] exp_mem[$], exp_buf[$], exp_disp[$], exp_hdr[$], exp_done[$];
   logic [112:0] exp_exec[$], h;
   bit halt = 1'b0, err = 1'b0;
   int pend;
   always #10 clk = ~clk;
   trp_byte_src src (.clk(clk), .in_valid(in_valid), .in_data(in_data));
   trp_parser dut (.clk(clk), .nrst(nrst), .in_valid(in_valid),
      .in_data(in_data), .err_clear(err_clear), .hdr_valid(hdr_valid),
      .rec_name(rec_name), .rec_number(rec_number),
      .record_type(record_type), .block_length(block_length),
      .rec_addr(rec_addr), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_data(mem_data), .buf_valid(buf_valid), .buf_data(buf_data),
      .disp_valid(disp_valid), .disp_data(disp_data), .src_stop(src_stop),
      .exec_req(exec_req), .exec_addr(exec_addr), .rec_done(rec_done),
      .csum_err(csum_err), .load_halt(load_halt));
   task automatic check(input logic [112:0] seen, input logic [112:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // an empty queue yields unknown, so a surplus pulse always mismatches
   function automatic logic [112:0] nxt(ref logic [112:0] qq[$]);
      return qq.size() ? qq.pop_front() : 'x;
   endfunction : nxt
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : final_report
   // reference model: builds one record and queues what must come out
   task automatic rec(input logic [7:0] tp, input logic [7:0] ln,
      input logic [15:0] adr, input int nsync, input bit bad_h, bad_d);
      logic [7:0] s, b;
      logic [63:0] name;
      logic [15:0] num;
      int n;
      bit ok, dat;
      n = (ln == 8'h00) ? 256 : ln;
      ok = nsync == 16 && !bad_h;
      dat = tp == 8'h00 || tp == 8'h01 || tp == 8'h04;
      repeat (nsync) q.push_back(8'he6);
      q.push_back(8'h01);
      s = 8'h00;
      for (int i = 0; i < 14; i++) begin
         b = i == 10 ? ln : i == 11 ? adr[7:0] : i == 12 ? adr[15:8] :
             i == 13 ? tp : ok ? 8'($urandom) : 8'h00;
         if (i < 8) name = {name[55:0], b};
         if (i == 8) num[7:0] = b;
         if (i == 9) num[15:8] = b;
         s += b;
         q.push_back(b);
      end
      q.push_back((8'h00 - s) ^ {7'h00, bad_h});
      if (ok) exp_hdr.push_back({name, num, tp, adr, 9'(n)});
      if (ok && tp == 8'h02) stop_exp++;
      if (ok && tp == 8'h03) exp_exec.push_back(adr);
      if (ok && !dat) exp_done.push_back({err, halt});
      if (!dat) return;
      s = 8'h00;
      for (int k = 0; k < n; k++) begin
         // rejected records carry no stray sync byte into the hunt
         b = ok ? 8'($urandom) : 8'h00;
         s += b;
         q.push_back(b);
         if (ok && tp == 8'h00 && !halt) exp_mem.push_back({adr + 16'(k), b});
         if (ok && tp == 8'h04 && !halt) exp_buf.push_back(b);
         if (ok && tp == 8'h01) exp_disp.push_back(b);
      end
      q.push_back((8'h00 - s) ^ {7'h00, bad_d});
      if (ok) begin
         if (bad_d && tp != 8'h01) err = 1'b1;
         // a clean comment record also lifts the halt
         halt = tp == 8'h01 ? halt && bad_d : bad_d;
         exp_done.push_back({err, halt});
      end
   endtask : rec
   // sends the queued bytes with random spacing up to gmax
   task automatic flush(input int gmax, input int tnum);
      logic [7:0] b;
      while (q.size()) begin
         b = q.pop_front();
         src.send(b, q.size() ? $urandom_range(gmax, 0) : 4);
      end
      $display("test %0d done", tnum);
   endtask : flush
   // output monitor, sampled mid-cycle where registered pulses are settled
   always @(negedge clk) begin
      if (nrst && mem_we) check({mem_addr, mem_data}, nxt(exp_mem));
      if (nrst && buf_valid) check(buf_data, nxt(exp_buf));
      if (nrst && disp_valid) check(disp_data, nxt(exp_disp));
      if (nrst && exec_req) check(exec_addr, nxt(exp_exec));
      if (nrst && src_stop) stops++;
      if (nrst && hdr_valid) begin
         h = nxt(exp_hdr);
         if (h[32:25] > 8'h00 && h[32:25] != 8'h03) h[24:9] = rec_addr;
         if (h[32:25] == 8'h02 || h[32:25] == 8'h03) h[8:0] = block_length;
         check({rec_name, rec_number, record_type, rec_addr,
            block_length}, h);
      end
      if (nrst && rec_done) begin
         h = nxt(exp_done);
         check(load_halt, h[0]);
         check(csum_err, h[1]);
      end
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         miscompares++;
         final_report();
      end
   end
   initial begin
      h = 113'($urandom(32'hc8c3));
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rec(8'h00, 8'h03, 16'hfffe, 16, 0, 0);
      rec(8'h00, 8'h01, 16'h1234, 16, 0, 0);
      rec(8'h04, 8'h00, 16'h0000, 16, 0, 0);
      flush(0, 1);
      rec(8'h01, 8'h05, 16'h0000, 16, 0, 1);
      rec(8'h04, 8'hff, 16'h5555, 16, 0, 0);
      flush(3, 2);
      rec(8'h00, 8'h08, 16'h2000, 16, 1, 0);
      rec(8'h02, 8'h00, 16'h0000, 15, 0, 0);
      rec(8'h02, 8'h00, 16'h0000, 17, 0, 0);
      rec(8'h02, 8'h00, 16'h0000, 16, 0, 0);
      rec(8'h03, 8'h00, 16'hbeef, 16, 0, 0);
      rec(8'h05, 8'h07, 16'h0000, 16, 0, 0);
      flush(2, 3);
      rec(8'h00, 8'h10, 16'h3000, 16, 0, 1);
      rec(8'h04, 8'h05, 16'h0000, 16, 0, 0);
      rec(8'h00, 8'h04, 16'h4000, 16, 0, 1);
      flush(1, 4);
      err_clear <= 1'b1;
      @(posedge clk);
      err_clear <= 1'b0;
      @(negedge clk);
      check({csum_err, load_halt}, 2'b00);
      halt = 1'b0;
      err = 1'b0;
      rec(8'h00, 8'h02, 16'h4100, 16, 0, 0);
      flush(1, 5);
      pend = exp_mem.size() + exp_buf.size() + exp_disp.size();
      pend += exp_hdr.size() + exp_done.size() + exp_exec.size();
      check(pend, 0);
      check(stops, stop_exp);
      final_report();
   end
endmodule : trp_parser_tb
`default_nettype wire
